// ### rtl/fss_state_ctrl.sv
/*
 * Slave communication state machine with its configuration registers,
 * datagram access filtering and station alias loading.
 * Assumes one datagram access per cycle at most, synchronous inputs, and
 * alias switches stable while reset is released.
 */
`timescale 1ns/1ns
`default_nettype none
`include "fss_defines.svh"

// Notes on behaviour
// - INIT refuses mailbox and process data
// - Leave INIT only with valid mailbox setup
// - SAFEOP needs checked channels and clock setup
// - SAFEOP: inputs valid, outputs not yet valid
// - State changes only on master requests
// - Combined read-write datagrams are refused
// - Channel 0: receive mailbox, 128 at 0x1000
// - Channel 1: transmit mailbox, 128 at 0x1080
// - Channel 2: outputs, up to 256 at 0x1100
// - Channel 3: inputs, up to 256 at 0x1400
// - Alias register 0x0012 loaded at power-up
// - Alias is high switch times 16 plus low
// - Mapping object writes only in PREOP
module fss_state_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire fss_pkg::fss_req_type req,
    input wire logic req_write,
    output logic rsp_valid,
    output fss_pkg::fss_rsp_type rsp,
    input wire logic [15:0] app_rdata,
    output logic app_wr,
    output logic [15:0] app_addr,
    output logic [15:0] app_wdata,
    input wire logic [3:0] alias_switch_high,
    input wire logic [3:0] alias_switch_low,
    input wire logic map_wr_valid,
    output logic map_wr_ok,
    output logic map_wr_refused,
    output logic [15:0] al_status,
    output logic mbx_enable,
    output logic pd_enable,
    output logic outputs_valid
);

    // Alias from the two rotary switches
    function automatic logic [15:0] alias_calc(input logic [3:0] hi, input logic [3:0] lo);
        alias_calc = 16'({4'h0, hi} * `FSS_ALIAS_SCALE) + {12'h000, lo};
    endfunction

    // Membership of an address in a half-open window
    function automatic logic in_win(input logic [15:0] a, input logic [15:0] lo,
        input logic [15:0] hi);
        in_win = a >= lo && a < hi;
    endfunction

    fss_pkg::fss_state_type state_reg, state_next;
    logic al_err_reg, al_err_next;
    logic [15:0] alias_reg, alias_next;
    logic alias_done_reg, alias_done_next;
    logic [15:0] sync_ctrl_reg, sync_ctrl_next;
    logic [15:0] dc_cycle_reg, dc_cycle_next;
    fss_pkg::fss_sm_cfg_type sm_reg [4];
    fss_pkg::fss_sm_cfg_type sm_next [4];
    logic [2:0] fmmu_en_reg, fmmu_en_next;
    logic rsp_valid_reg, rsp_valid_next;
    fss_pkg::fss_rsp_type rsp_reg, rsp_next;
    logic app_wr_reg, app_wr_next;
    logic [15:0] app_addr_reg, app_addr_next;
    logic [15:0] app_wdata_reg, app_wdata_next;
    logic map_ok_reg, map_ok_next;
    logic map_ref_reg, map_ref_next;
    logic mbx_en_reg, mbx_en_next, pd_en_reg, pd_en_next, ov_reg, ov_next;
    logic mbx_ok, pd_ok, dc_ok;
    logic is_rw, is_read, is_write;
    logic sm_hit, fmmu_hit;
    logic [1:0] sm_idx;
    logic [1:0] fmmu_idx;
    logic [3:0] req_state;

    // Layout check of the sync channels
    fss_sm_check u_check (
        .sm0(sm_reg[0]),
        .sm1(sm_reg[1]),
        .sm2(sm_reg[2]),
        .sm3(sm_reg[3]),
        .mbx_ok(mbx_ok),
        .pd_ok(pd_ok)
    );

    // Command class and register block decode
    always_comb
    begin
        is_rw = req.cmd == `FSS_CMD_APRW || req.cmd == `FSS_CMD_FPRW
            || req.cmd == `FSS_CMD_BRW || req.cmd == `FSS_CMD_LRW;
        is_read = !is_rw && !req_write;
        is_write = !is_rw && req_write;
        sm_hit = req.addr[15:5] == `FSS_ADDR_SM_BASE >> 5;
        sm_idx = req.addr[4:3];
        fmmu_hit = req.addr[15:6] == `FSS_ADDR_FMMU_BASE >> 6 && req.addr[5:4] != 2'h3;
        fmmu_idx = req.addr[5:4];
        req_state = req.wdata[3:0];
        dc_ok = sync_ctrl_reg != `FSS_SYNC_DC_MODE || dc_cycle_reg != `FSS_RST_WORD;
    end

    // State machine driven by AL control writes only
    always_comb
    begin
        state_next = state_reg;
        al_err_next = al_err_reg;
        if (req_valid && is_write && req.addr == `FSS_ADDR_AL_CONTROL)
        begin
            al_err_next = 1'b0;
            case (state_reg)
                fss_pkg::ST_INIT:
                begin
                    if (req_state == fss_pkg::ST_INIT)
                        state_next = fss_pkg::ST_INIT;
                    else if (req_state == fss_pkg::ST_PREOP && mbx_ok)
                        state_next = fss_pkg::ST_PREOP;
                    else
                        al_err_next = 1'b1;
                end
                fss_pkg::ST_PREOP:
                begin
                    if (req_state == fss_pkg::ST_INIT || req_state == fss_pkg::ST_PREOP)
                        state_next = fss_pkg::fss_state_type'(req_state);
                    else if (req_state == fss_pkg::ST_SAFEOP && pd_ok && dc_ok)
                        state_next = fss_pkg::ST_SAFEOP;
                    else
                        al_err_next = 1'b1;
                end
                fss_pkg::ST_SAFEOP:
                begin
                    if (req_state == fss_pkg::ST_INIT || req_state == fss_pkg::ST_PREOP
                        || req_state == fss_pkg::ST_SAFEOP || req_state == fss_pkg::ST_OP)
                        state_next = fss_pkg::fss_state_type'(req_state);
                    else
                        al_err_next = 1'b1;
                end
                fss_pkg::ST_OP:
                begin
                    if (req_state == fss_pkg::ST_INIT || req_state == fss_pkg::ST_PREOP
                        || req_state == fss_pkg::ST_SAFEOP || req_state == fss_pkg::ST_OP)
                        state_next = fss_pkg::fss_state_type'(req_state);
                    else
                        al_err_next = 1'b1;
                end
                default:
                begin
                    state_next = fss_pkg::ST_INIT;
                end
            endcase
        end
        mbx_en_next = state_next != fss_pkg::ST_INIT;
        pd_en_next = state_next == fss_pkg::ST_SAFEOP || state_next == fss_pkg::ST_OP;
        ov_next = state_next == fss_pkg::ST_OP;
    end

    // Configuration register writes
    always_comb
    begin
        sync_ctrl_next = sync_ctrl_reg;
        dc_cycle_next = dc_cycle_reg;
        fmmu_en_next = fmmu_en_reg;
        for (int i = 0; i < 4; i++)
        begin
            sm_next[i] = sm_reg[i];
        end
        if (req_valid && is_write)
        begin
            if (req.addr == `FSS_ADDR_SYNC_CTRL)
                sync_ctrl_next = req.wdata;
            if (req.addr == `FSS_ADDR_DC_CYCLE)
                dc_cycle_next = req.wdata;
            if (sm_hit && req.addr[2:0] == `FSS_SM_OFS_START)
                sm_next[sm_idx].start = req.wdata;
            if (sm_hit && req.addr[2:0] == `FSS_SM_OFS_LEN)
                sm_next[sm_idx].len = req.wdata;
            if (sm_hit && req.addr[2:0] == `FSS_SM_OFS_CTRL)
                sm_next[sm_idx].en = req.wdata[0];
            if (fmmu_hit && req.addr[3:0] == `FSS_FMMU_OFS_EN)
                fmmu_en_next[fmmu_idx] = req.wdata[0];
        end
    end

    // Alias captured once, on the first edge after reset release
    always_comb
    begin
        alias_next = alias_reg;
        alias_done_next = 1'b1;
        if (!alias_done_reg)
            alias_next = alias_calc(alias_switch_high, alias_switch_low);
    end

    // Datagram answer, memory window filtering and application strobe
    always_comb
    begin
        rsp_valid_next = req_valid;
        rsp_next = '0;
        app_wr_next = 1'b0;
        app_addr_next = app_addr_reg;
        app_wdata_next = app_wdata_reg;
        if (req_valid)
        begin
            rsp_next.ack = 1'b1;
            if (is_rw)
            begin
                rsp_next.ack = 1'b0;
                rsp_next.refused = 1'b1;
            end
            else if (in_win(req.addr, `FSS_MBX_LO, `FSS_MBX_HI))
            begin
                if (state_reg == fss_pkg::ST_INIT)
                begin
                    rsp_next.ack = 1'b0;
                    rsp_next.refused = 1'b1;
                end
                else
                begin
                    rsp_next.rdata = is_read ? app_rdata : `FSS_RST_WORD;
                    app_wr_next = is_write;
                    app_addr_next = req.addr;
                    app_wdata_next = req.wdata;
                end
            end
            else if (in_win(req.addr, `FSS_RXPD_LO, `FSS_RXPD_HI)
                || in_win(req.addr, `FSS_TXPD_LO, `FSS_TXPD_HI))
            begin
                if (state_reg == fss_pkg::ST_INIT || state_reg == fss_pkg::ST_PREOP
                    || !fmmu_en_reg[in_win(req.addr, `FSS_TXPD_LO, `FSS_TXPD_HI)])
                begin
                    rsp_next.ack = 1'b0;
                    rsp_next.refused = 1'b1;
                end
                else
                begin
                    rsp_next.rdata = is_read ? app_rdata : `FSS_RST_WORD;
                    app_wr_next = is_write;
                    app_addr_next = req.addr;
                    app_wdata_next = req.wdata;
                end
            end
            else if (is_read)
            begin
                if (req.addr == `FSS_ADDR_ALIAS)
                    rsp_next.rdata = alias_reg;
                else if (req.addr == `FSS_ADDR_AL_STATUS)
                    rsp_next.rdata = {11'h000, al_err_reg, state_reg};
                else if (req.addr == `FSS_ADDR_SYNC_CTRL)
                    rsp_next.rdata = sync_ctrl_reg;
                else if (req.addr == `FSS_ADDR_DC_CYCLE)
                    rsp_next.rdata = dc_cycle_reg;
                else if (sm_hit && req.addr[2:0] == `FSS_SM_OFS_START)
                    rsp_next.rdata = sm_reg[sm_idx].start;
                else if (sm_hit && req.addr[2:0] == `FSS_SM_OFS_LEN)
                    rsp_next.rdata = sm_reg[sm_idx].len;
                else if (sm_hit && req.addr[2:0] == `FSS_SM_OFS_CTRL)
                    rsp_next.rdata = {15'h0000, sm_reg[sm_idx].en};
                else if (fmmu_hit && req.addr[3:0] == `FSS_FMMU_OFS_EN)
                    rsp_next.rdata = {15'h0000, fmmu_en_reg[fmmu_idx]};
            end
        end
    end

    // Mapping object write permission
    always_comb
    begin
        map_ok_next = map_wr_valid && state_reg == fss_pkg::ST_PREOP;
        map_ref_next = map_wr_valid && state_reg != fss_pkg::ST_PREOP;
    end

    // Register stage for every group
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= fss_pkg::ST_INIT;
            al_err_reg <= 1'b0;
            alias_reg <= `FSS_RST_WORD;
            alias_done_reg <= 1'b0;
            sync_ctrl_reg <= `FSS_RST_WORD;
            dc_cycle_reg <= `FSS_RST_WORD;
            for (int i = 0; i < 4; i++)
            begin
                sm_reg[i] <= '0;
            end
            fmmu_en_reg <= 3'h0;
            rsp_valid_reg <= 1'b0;
            rsp_reg <= '0;
            app_wr_reg <= 1'b0;
            app_addr_reg <= `FSS_RST_WORD;
            app_wdata_reg <= `FSS_RST_WORD;
            map_ok_reg <= 1'b0;
            map_ref_reg <= 1'b0;
            mbx_en_reg <= 1'b0;
            pd_en_reg <= 1'b0;
            ov_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            al_err_reg <= al_err_next;
            alias_reg <= alias_next;
            alias_done_reg <= alias_done_next;
            sync_ctrl_reg <= sync_ctrl_next;
            dc_cycle_reg <= dc_cycle_next;
            for (int i = 0; i < 4; i++)
            begin
                sm_reg[i] <= sm_next[i];
            end
            fmmu_en_reg <= fmmu_en_next;
            rsp_valid_reg <= rsp_valid_next;
            rsp_reg <= rsp_next;
            app_wr_reg <= app_wr_next;
            app_addr_reg <= app_addr_next;
            app_wdata_reg <= app_wdata_next;
            map_ok_reg <= map_ok_next;
            map_ref_reg <= map_ref_next;
            mbx_en_reg <= mbx_en_next;
            pd_en_reg <= pd_en_next;
            ov_reg <= ov_next;
        end
    end

    // Outputs straight from flip-flops
    assign rsp_valid = rsp_valid_reg;
    assign rsp = rsp_reg;
    assign app_wr = app_wr_reg;
    assign app_addr = app_addr_reg;
    assign app_wdata = app_wdata_reg;
    assign map_wr_ok = map_ok_reg;
    assign map_wr_refused = map_ref_reg;
    assign al_status = {11'h000, al_err_reg, state_reg};
    assign mbx_enable = mbx_en_reg;
    assign pd_enable = pd_en_reg;
    assign outputs_valid = ov_reg;

endmodule
`default_nettype wire

// ### rtl/fss_defines.svh
/*
 * Offsets, fixed layout values, command codes and reset values of the
 * fieldbus slave communication state logic.
 * Assumes 16-bit register words and byte addresses on the datagram port.
 */
`ifndef FSS_DEFINES_SVH
`define FSS_DEFINES_SVH

// Register offsets
`define FSS_ADDR_ALIAS 16'h0012
`define FSS_ADDR_AL_CONTROL 16'h0120
`define FSS_ADDR_AL_STATUS 16'h0130
`define FSS_ADDR_SYNC_CTRL 16'h0980
`define FSS_ADDR_DC_CYCLE 16'h09A0
`define FSS_ADDR_SM_BASE 16'h0800
`define FSS_ADDR_FMMU_BASE 16'h0600

// Sync channel register block: 8 bytes per channel
`define FSS_SM_STRIDE_LSB 3
`define FSS_SM_OFS_START 3'h0
`define FSS_SM_OFS_LEN 3'h2
`define FSS_SM_OFS_CTRL 3'h4
// FMMU register block: 16 bytes per channel, enable word at +0xC
`define FSS_FMMU_STRIDE_LSB 4
`define FSS_FMMU_OFS_EN 4'hC

// Fixed sync channel layout
`define FSS_SM0_START 16'h1000
`define FSS_SM1_START 16'h1080
`define FSS_SM2_START 16'h1100
`define FSS_SM3_START 16'h1400
`define FSS_MBX_LEN 16'h0080
`define FSS_PD_MAX_LEN 16'h0100

// Memory windows
`define FSS_MBX_LO 16'h1000
`define FSS_MBX_HI 16'h1100
`define FSS_RXPD_LO 16'h1100
`define FSS_RXPD_HI 16'h1200
`define FSS_TXPD_LO 16'h1400
`define FSS_TXPD_HI 16'h1500

// Sync control value selecting clock-synchronised mode
`define FSS_SYNC_DC_MODE 16'h0300

// Datagram command codes
`define FSS_CMD_APRD 8'h01
`define FSS_CMD_APWR 8'h02
`define FSS_CMD_APRW 8'h03
`define FSS_CMD_FPRD 8'h04
`define FSS_CMD_FPWR 8'h05
`define FSS_CMD_FPRW 8'h06
`define FSS_CMD_BRD 8'h07
`define FSS_CMD_BWR 8'h08
`define FSS_CMD_BRW 8'h09
`define FSS_CMD_LRD 8'h0A
`define FSS_CMD_LWR 8'h0B
`define FSS_CMD_LRW 8'h0C

// AL status error flag position, reset value and alias switch scale
`define FSS_AL_ERR_BIT 4
`define FSS_RST_WORD 16'h0000
`define FSS_ALIAS_SCALE 8'h10

`endif

// ### rtl/fss_pkg.sv
/*
 * Types of the fieldbus slave communication state logic.
 * Assumes the constants header is included where the numbers are needed.
 */
package fss_pkg;

    // Communication states, codes equal the AL status state field
    typedef enum logic [3:0] {
        ST_INIT = 4'b0001,
        ST_PREOP = 4'b0010,
        ST_SAFEOP = 4'b0100,
        ST_OP = 4'b1000
    } fss_state_type;

    // One datagram access arriving from the network
    typedef struct packed {
        logic [7:0] cmd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } fss_req_type;

    // Answer to one datagram access
    typedef struct packed {
        logic [15:0] rdata;
        logic ack;
        logic refused;
    } fss_rsp_type;

    // One sync channel configuration
    typedef struct packed {
        logic [15:0] start;
        logic [15:0] len;
        logic en;
    } fss_sm_cfg_type;

endpackage

// ### rtl/fss_sm_check.sv
/*
 * Checks the sync channel configuration against the fixed layout.
 * Assumes the four configurations come straight from registers.
 */
`timescale 1ns/1ns
`default_nettype none
`include "fss_defines.svh"

module fss_sm_check (
    input wire fss_pkg::fss_sm_cfg_type sm0,
    input wire fss_pkg::fss_sm_cfg_type sm1,
    input wire fss_pkg::fss_sm_cfg_type sm2,
    input wire fss_pkg::fss_sm_cfg_type sm3,
    output logic mbx_ok,
    output logic pd_ok
);

    // Mailbox channels: fixed start, fixed length, enabled
    always_comb
    begin
        mbx_ok = sm0.en && sm0.start == `FSS_SM0_START && sm0.len == `FSS_MBX_LEN
            && sm1.en && sm1.start == `FSS_SM1_START && sm1.len == `FSS_MBX_LEN;
    end

    // Process data channels: fixed start, length within the area
    always_comb
    begin
        pd_ok = sm2.start == `FSS_SM2_START && sm2.len <= `FSS_PD_MAX_LEN
            && sm3.start == `FSS_SM3_START && sm3.len <= `FSS_PD_MAX_LEN;
    end

endmodule
`default_nettype wire

// ### verif/fss_state_ctrl_chk.sv
/* Concurrent checks on the ports of fss_state_ctrl.
   Assumes one clock, async active-high reset, switches stable after reset. */
`timescale 1ns/1ns
`default_nettype none
`include "fss_defines.svh"

module fss_state_ctrl_chk (
    input wire logic clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire fss_pkg::fss_req_type req,
    input wire logic req_write,
    input wire logic rsp_valid,
    input wire fss_pkg::fss_rsp_type rsp,
    input wire logic [15:0] app_rdata,
    input wire logic app_wr,
    input wire logic [15:0] app_addr,
    input wire logic [15:0] app_wdata,
    input wire logic [3:0] alias_switch_high,
    input wire logic [3:0] alias_switch_low,
    input wire logic map_wr_valid,
    input wire logic map_wr_ok,
    input wire logic map_wr_refused,
    input wire logic [15:0] al_status,
    input wire logic mbx_enable,
    input wire logic pd_enable,
    input wire logic outputs_valid
);
    logic [1:0] up_reg;
    logic [1:0] up_next;
    logic rw_cmd;
    logic ctl_wr;
    logic [3:0] st;

    // Decoded request kinds and current state
    assign st = al_status[3:0];
    assign rw_cmd = req.cmd == `FSS_CMD_APRW || req.cmd == `FSS_CMD_FPRW
        || req.cmd == `FSS_CMD_BRW || req.cmd == `FSS_CMD_LRW;
    assign ctl_wr = req_valid && req_write && !rw_cmd && req.addr == `FSS_ADDR_AL_CONTROL;

    // Edges since reset release, saturating
    always_comb
    begin
        up_next = (up_reg == 2'h3) ? up_reg : up_reg + 2'h1;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            up_reg <= 2'h0;
        else
            up_reg <= up_next;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    AST_RSP_NEXT: assert property (req_valid |=> rsp_valid)
        else $error("no answer one edge after request");
    AST_RSP_IDLE: assert property (!req_valid |=> !rsp_valid && rsp == '0)
        else $error("answer without request");
    AST_RW_REFUSED: assert property (req_valid && rw_cmd
        |=> rsp.refused && !rsp.ack && $stable(st))
        else $error("read-write command not refused");
    AST_INIT_IDLE: assert property (st == 4'h1
        |-> !mbx_enable && !pd_enable && !outputs_valid)
        else $error("traffic enabled in init");
    AST_INIT_MBX: assert property (req_valid && !rw_cmd && st == 4'h1
        && req.addr[15:8] == 8'h10 |=> rsp.refused && !app_wr)
        else $error("mailbox access in init");
    AST_SAFEOP: assert property (st == 4'h4 |-> mbx_enable && pd_enable && !outputs_valid)
        else $error("wrong enables in safe state");
    AST_OP: assert property (st == 4'h8 |-> mbx_enable && pd_enable && outputs_valid)
        else $error("wrong enables in operational state");
    AST_STATE_HOLD: assert property (!ctl_wr |=> $stable(st))
        else $error("state moved without request");
    AST_TO_INIT: assert property (ctl_wr && req.wdata[3:0] == 4'h1
        |=> al_status[4:0] == 5'h01)
        else $error("downward request not reported");
    AST_ALIAS: assert property (up_reg == 2'h3 && req_valid && !req_write && !rw_cmd
        && req.addr == `FSS_ADDR_ALIAS
        |=> rsp.rdata == {8'h00, alias_switch_high, alias_switch_low})
        else $error("alias value wrong");
    AST_MAP: assert property (map_wr_valid
        |=> map_wr_ok == ($past(st) == 4'h2) && map_wr_refused != map_wr_ok)
        else $error("mapping write answer wrong");
endmodule

bind fss_state_ctrl fss_state_ctrl_chk chk (.clk(clk), .rst(rst), .req_valid(req_valid),
    .req(req), .req_write(req_write), .rsp_valid(rsp_valid), .rsp(rsp),
    .app_rdata(app_rdata), .app_wr(app_wr), .app_addr(app_addr), .app_wdata(app_wdata),
    .alias_switch_high(alias_switch_high), .alias_switch_low(alias_switch_low),
    .map_wr_valid(map_wr_valid), .map_wr_ok(map_wr_ok), .map_wr_refused(map_wr_refused),
    .al_status(al_status), .mbx_enable(mbx_enable), .pd_enable(pd_enable),
    .outputs_valid(outputs_valid));

`default_nettype wire

// ### verif/fss_master_model.sv
/* Network master model issuing one datagram access at a time.
   Assumes the answer is registered on the taking edge and read at the next falling edge. */
`timescale 1ns/1ns
`default_nettype none

module fss_master_model (
    input wire logic clk,
    input wire logic rsp_valid,
    input wire fss_pkg::fss_rsp_type rsp,
    output logic req_valid,
    output fss_pkg::fss_req_type req,
    output logic req_write
);
    logic last_valid;
    fss_pkg::fss_rsp_type last_rsp;

    // Idle bus at time zero
    initial
    begin
        req_valid = 1'b0;
        req = '0;
        req_write = 1'b0;
    end

    // Held from a falling edge across the taking edge, then released
    task automatic access(input logic [7:0] c, input logic [15:0] a, input logic [15:0] d,
        input logic w);
        @(negedge clk);
        req_valid = 1'b1;
        req = '{c, a, d};
        req_write = w;
        @(negedge clk);
        last_valid = rsp_valid;
        last_rsp = rsp;
        req_valid = 1'b0;
        req = fss_pkg::fss_req_type'(~req); // Released fields show no stale value
        req_write = ~w;
    endtask
endmodule

`default_nettype wire

// ### verif/tb_top.sv
/* Self-checking bench for fss_state_ctrl.
   Master model issues datagrams; the bench plays the application side. */
`timescale 1ns/1ns
`default_nettype none
`include "fss_defines.svh"

module tb_top;
    logic clk;
    logic rst;
    logic req_valid;
    fss_pkg::fss_req_type req;
    logic req_write;
    logic rsp_valid;
    fss_pkg::fss_rsp_type rsp;
    logic [15:0] app_rdata;
    logic app_wr;
    logic [15:0] app_addr;
    logic [15:0] app_wdata;
    logic [3:0] sw_hi;
    logic [3:0] sw_lo;
    logic map_wr_valid;
    logic map_wr_ok;
    logic map_wr_refused;
    logic [15:0] al_status;
    logic mbx_enable;
    logic pd_enable;
    logic outputs_valid;
    int error_cnt;
    int n_tests;
    logic [7:0] rw_codes [4];

    // 20 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    fss_state_ctrl uut (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req),
        .req_write(req_write), .rsp_valid(rsp_valid), .rsp(rsp), .app_rdata(app_rdata),
        .app_wr(app_wr), .app_addr(app_addr), .app_wdata(app_wdata),
        .alias_switch_high(sw_hi), .alias_switch_low(sw_lo), .map_wr_valid(map_wr_valid),
        .map_wr_ok(map_wr_ok), .map_wr_refused(map_wr_refused), .al_status(al_status),
        .mbx_enable(mbx_enable), .pd_enable(pd_enable), .outputs_valid(outputs_valid));

    fss_master_model m (.clk(clk), .rsp_valid(rsp_valid), .rsp(rsp), .req_valid(req_valid),
        .req(req), .req_write(req_write));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_rsp(input logic rf, input logic [15:0] d);
        chk({13'h0000, m.last_valid, m.last_rsp.ack, m.last_rsp.refused},
            {13'h0000, 1'b1, !rf, rf});
        chk(m.last_rsp.rdata, d);
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        m.access(`FSS_CMD_FPWR, a, d, 1'b1);
    endtask

    task automatic rd(input logic [7:0] c, input logic [15:0] a, input logic rf,
        input logic [15:0] d);
        m.access(c, a, 16'h0000, 1'b0);
        chk_rsp(rf, d);
    endtask

    // State request, then the reported status
    task automatic st_req(input logic [15:0] d, input logic [15:0] exp);
        wr(`FSS_ADDR_AL_CONTROL, d);
        chk(al_status, exp);
    endtask

    // Sync channel start, length and enable
    task automatic sm(input logic [1:0] n, input logic [15:0] s, input logic [15:0] l);
        wr(`FSS_ADDR_SM_BASE + {11'h000, n, 3'h0}, s);
        wr(`FSS_ADDR_SM_BASE + {11'h000, n, 3'h2}, l);
        wr(`FSS_ADDR_SM_BASE + {11'h000, n, 3'h4}, 16'h0001);
    endtask

    task automatic map(input logic ok);
        @(negedge clk);
        map_wr_valid = 1'b1;
        @(negedge clk);
        map_wr_valid = 1'b0;
        chk({14'h0000, map_wr_ok, map_wr_refused}, {14'h0000, ok, !ok});
    endtask

    task automatic summarize;
        $display("errors %0d, checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        $display("unexpected at %0t: watchdog expired", $time);
        summarize();
    end

    // Main sequence
    initial
    begin
        error_cnt = 0;
        n_tests = 0;
        rst = 1'b1;
        map_wr_valid = 1'b0;
        app_rdata = 16'h5A3C;
        sw_hi = 4'hA;
        sw_lo = 4'h5;
        rw_codes = '{`FSS_CMD_APRW, `FSS_CMD_FPRW, `FSS_CMD_BRW, `FSS_CMD_LRW};
        repeat (2) @(negedge clk);
        chk(al_status, 16'h0001);
        rst = 1'b0;
        rd(`FSS_CMD_APRD, `FSS_ADDR_ALIAS, 1'b0, 16'h00A5);
        wr(`FSS_ADDR_ALIAS, 16'h1234);
        rd(`FSS_CMD_FPRD, `FSS_ADDR_ALIAS, 1'b0, 16'h00A5);
        rd(`FSS_CMD_FPRD, `FSS_SM0_START, 1'b1, 16'h0000);
        map(1'b0);
        st_req(16'h0002, 16'h0011);
        sm(2'h0, 16'h1000, 16'h0040);
        sm(2'h1, 16'h1080, 16'h0080);
        st_req(16'h0002, 16'h0011);
        sm(2'h0, 16'h1000, 16'h0080);
        sm(2'h1, 16'h1088, 16'h0080);
        st_req(16'h0002, 16'h0011);
        sm(2'h1, 16'h1080, 16'h0080);
        st_req(16'h0002, 16'h0002);
        chk({14'h0000, mbx_enable, pd_enable}, 16'h0002);
        rd(`FSS_CMD_FPRD, `FSS_SM1_START, 1'b0, 16'h5A3C);
        rd(`FSS_CMD_FPRD, `FSS_SM2_START, 1'b1, 16'h0000);
        map(1'b1);
        foreach (rw_codes[i])
        begin
            m.access(rw_codes[i], `FSS_ADDR_AL_CONTROL, 16'h0001, 1'b1);
            chk_rsp(1'b1, 16'h0000);
            chk(al_status, 16'h0002);
        end
        st_req(16'h0004, 16'h0012);
        wr(`FSS_ADDR_FMMU_BASE + 16'h000C, 16'h0001);
        wr(`FSS_ADDR_FMMU_BASE + 16'h001C, 16'h0001);
        wr(`FSS_ADDR_FMMU_BASE + 16'h002C, 16'h0001);
        sm(2'h2, 16'h1100, 16'h0101);
        sm(2'h3, 16'h1400, 16'h0100);
        st_req(16'h0004, 16'h0012);
        sm(2'h2, 16'h1100, 16'h0100);
        sm(2'h3, 16'h1404, 16'h0000);
        st_req(16'h0004, 16'h0012);
        sm(2'h3, 16'h1400, 16'h0000);
        wr(`FSS_ADDR_SYNC_CTRL, `FSS_SYNC_DC_MODE);
        st_req(16'h0004, 16'h0012);
        wr(`FSS_ADDR_DC_CYCLE, 16'h0001);
        st_req(16'h0004, 16'h0004);
        chk({13'h0000, mbx_enable, pd_enable, outputs_valid}, 16'h0006);
        rd(`FSS_CMD_LRD, `FSS_SM3_START, 1'b0, 16'h5A3C);
        m.access(`FSS_CMD_LWR, `FSS_SM2_START, 16'hC3A5, 1'b1);
        chk({app_wr, app_addr[14:0]}, 16'h9100);
        chk(app_wdata, 16'hC3A5);
        map(1'b0);
        st_req(16'h0008, 16'h0008);
        chk({15'h0000, outputs_valid}, 16'h0001);
        st_req(16'h0001, 16'h0001);
        st_req(16'h0008, 16'h0011);
        @(negedge clk);
        rst = 1'b1;
        sw_hi = 4'h3;
        sw_lo = 4'hC;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd(`FSS_CMD_APRD, `FSS_ADDR_ALIAS, 1'b0, 16'h003C);
        chk(al_status, 16'h0001);
        summarize();
    end
endmodule

`default_nettype wire
